// *** icc_pkg.sv ***
package icc_pkg;
   // ==========================================
   // Register map
   localparam logic [31:0] ADDR_CTRL1 = 32'h400C3000;
   localparam logic [31:0] ADDR_LINE = 32'h400C3004;
   localparam logic [31:0] ADDR_WAY = 32'h400C3008;
   localparam logic [31:0] ADDR_CTRL2 = 32'h400C3020;
   // ==========================================
   // Field positions
   localparam int CTRL1_FLUSH_BIT = 0;
   localparam int CTRL1_RES_BIT = 1;
   localparam int CTRL2_FLASH_BIT = 12;
   localparam int CTRL2_OTP_BIT = 11;
   localparam int CTRL2_CGEN_BIT = 10;
   localparam int CTRL2_WEN_BIT = 9;
   localparam int CTRL2_LEN_MSB = 8;
   localparam int CTRL2_W = 13;
   localparam int REGION_SHIFT = 16;
   localparam int OFFSET_W = 25;
   // ==========================================
   // Reset values and codes
   localparam logic [1:0] LINE_8B = 2'h0;
   localparam logic [1:0] LINE_16B = 2'h1;
   localparam logic [1:0] LINE_32B = 2'h2;
   localparam logic [1:0] WAY_1 = 2'h0;
   localparam logic [1:0] WAY_2 = 2'h1;
   localparam logic [1:0] WAY_4 = 2'h2;
   localparam logic [1:0] LINE_RST = LINE_8B;
   localparam logic [1:0] WAY_RST = WAY_4;
   localparam logic [12:0] CTRL2_RST = 13'h0000;
   localparam logic [31:0] FLUSH_WORD = 32'h00000001;
   localparam logic [15:0] TAG_MASK = 16'hFFFF;
   // Units of 64 KB; 16 MB is 256 units
   localparam logic [9:0] UNITS_OTP_MAX = 10'h100;
   // ==========================================
   // Timing
   localparam logic [9:0] FLUSH_CYC_8KB = 10'h100;
   localparam logic [9:0] FLUSH_CYC_16KB = 10'h200;

   function automatic logic [9:0] flush_cycles(input int kb);
      return (kb <= 8) ? FLUSH_CYC_8KB : FLUSH_CYC_16KB;
   endfunction : flush_cycles
endpackage : icc_pkg

// *** icc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface icc_link_if;
   logic reg_req;
   logic reg_we;
   logic [31:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic reg_ack;
   logic arr_req;
   logic arr_we;
   logic arr_tag;
   logic [15:0] arr_addr;
   logic [31:0] arr_wdata;
   logic [31:0] arr_rdata;
   logic arr_ack;

   modport dev(
      input reg_req, reg_we, reg_addr, reg_wdata,
      input arr_req, arr_we, arr_tag, arr_addr, arr_wdata,
      output reg_rdata, reg_ack, arr_rdata, arr_ack
   );
   modport host(
      output reg_req, reg_we, reg_addr, reg_wdata,
      output arr_req, arr_we, arr_tag, arr_addr, arr_wdata,
      input reg_rdata, reg_ack, arr_rdata, arr_ack
   );
endinterface : icc_link_if
`default_nettype wire

// *** icc_flush_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module icc_flush_timer #(
   parameter int DATA_KB = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   output logic o_busy,
   output logic [9:0] o_idx
);
   localparam logic [9:0] LAST = 10'(icc_pkg::flush_cycles(DATA_KB) - 10'h001);

   typedef struct packed {
      logic busy;
      logic [9:0] cnt;
   } icc_tmr_type;

   icc_tmr_type r_reg;
   icc_tmr_type r_next;

   // ==========================================
   // Walk every tag index once per flush
   always_comb
   begin
      r_next = r_reg;
      if (i_start)
      begin
         // A new flush restarts the sweep from index zero
         r_next.busy = 1'b1;
         r_next.cnt = 10'h000;
      end
      else if (r_reg.busy)
      begin
         if (r_reg.cnt == LAST)
            r_next.busy = 1'b0;
         else
            r_next.cnt = r_reg.cnt + 10'h001;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign o_busy = r_reg.busy;
   assign o_idx = r_reg.cnt;
endmodule : icc_flush_timer
`default_nettype wire

// *** icc_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module icc_dev #(
   parameter int DATA_KB = 16
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   icc_link_if.dev LINK,
   input wire logic I_ACC_VALID,
   input wire logic I_ACC_FLASH,
   input wire logic I_ACC_OTP,
   input wire logic [24:0] I_ACC_OFFSET,
   input wire logic I_REMAP_OTP,
   input wire logic I_TAG_HIT,
   input wire logic [31:0] I_MEM_RDATA,
   output logic O_CACHEABLE,
   output logic O_HIT,
   output logic O_STALL,
   output logic [1:0] O_LINE_SIZE,
   output logic [1:0] O_WAY_COUNT,
   output logic O_CACHE_EN,
   output logic [9:0] O_FLASH_UNITS,
   output logic O_CLK_GATE_EN,
   output logic O_ARRAY_WEN,
   output logic O_FLUSH_BUSY,
   output logic O_TAG_CLR_EN,
   output logic [9:0] O_TAG_CLR_IDX,
   output logic O_MEM_REQ,
   output logic O_MEM_WE,
   output logic O_MEM_TAG,
   output logic [15:0] O_MEM_ADDR,
   output logic [31:0] O_MEM_WDATA
);
   typedef struct packed {
      logic res_keep_zero;
      logic [1:0] line_size;
      logic [1:0] way_count_sel;
      logic [12:0] ctrl2;
      logic reg_ack;
      logic [31:0] reg_rdata;
      logic [1:0] arr_stage;
      logic arr_ack;
      logic [31:0] arr_rdata;
      logic mem_req;
      logic mem_we;
      logic mem_tag;
      logic [15:0] mem_addr;
      logic [31:0] mem_wdata;
      logic cache_en;
      logic [9:0] units;
   } icc_dev_type;

   icc_dev_type r_reg;
   icc_dev_type r_next;
   logic flush_start;
   logic flush_busy;
   logic [9:0] flush_idx;
   logic otp_mode;
   logic [9:0] units_raw;
   logic flash_ok;
   logic otp_ok;
   logic cacheable;

   // ==========================================
   // Tag invalidation sweep
   icc_flush_timer #(
      .DATA_KB(DATA_KB)
   ) u_flush (
      .i_clk(I_CLK),
      .i_rst(I_RST),
      .i_start(flush_start),
      .o_busy(flush_busy),
      .o_idx(flush_idx)
   );

   assign flush_start = LINK.reg_req && LINK.reg_we
      && (LINK.reg_addr == icc_pkg::ADDR_CTRL1)
      && LINK.reg_wdata[icc_pkg::CTRL1_FLUSH_BIT];

   // ==========================================
   // Region decode
   always_comb
   begin
      // OTP counts as cached when it is the remapped code or bit 11 is set
      otp_mode = I_REMAP_OTP || r_reg.ctrl2[icc_pkg::CTRL2_OTP_BIT];
      units_raw = {1'b0, r_reg.ctrl2[icc_pkg::CTRL2_LEN_MSB:0]} + 10'h001;
      flash_ok = I_ACC_FLASH
         && (!I_REMAP_OTP || r_reg.ctrl2[icc_pkg::CTRL2_FLASH_BIT])
         && ({1'b0, I_ACC_OFFSET[icc_pkg::OFFSET_W-1:icc_pkg::REGION_SHIFT]}
            < r_reg.units);
      // Offset is ignored for OTP: the whole device is cacheable
      otp_ok = I_ACC_OTP
         && (I_REMAP_OTP || r_reg.ctrl2[icc_pkg::CTRL2_OTP_BIT]);
      cacheable = r_reg.cache_en && (flash_ok || otp_ok);
   end

   // ==========================================
   // Register file and array port
   always_comb
   begin
      r_next = r_reg;
      r_next.reg_ack = 1'b0;
      r_next.arr_ack = 1'b0;
      r_next.mem_req = 1'b0;
      r_next.mem_we = 1'b0;
      r_next.cache_en = (r_reg.ctrl2[icc_pkg::CTRL2_LEN_MSB:0] != 9'h000);
      if (otp_mode && (units_raw > icc_pkg::UNITS_OTP_MAX))
         r_next.units = icc_pkg::UNITS_OTP_MAX;
      else
         r_next.units = units_raw;

      if (LINK.reg_req)
      begin
         r_next.reg_ack = 1'b1;
         r_next.reg_rdata = 32'h00000000;
         case (LINK.reg_addr)
            icc_pkg::ADDR_CTRL1:
            begin
               // Flush bit is write-only and always reads zero
               r_next.reg_rdata[icc_pkg::CTRL1_RES_BIT] = r_reg.res_keep_zero;
               if (LINK.reg_we)
                  r_next.res_keep_zero = LINK.reg_wdata[icc_pkg::CTRL1_RES_BIT];
            end
            icc_pkg::ADDR_LINE:
            begin
               r_next.reg_rdata[1:0] = r_reg.line_size;
               if (LINK.reg_we)
                  r_next.line_size = LINK.reg_wdata[1:0];
            end
            icc_pkg::ADDR_WAY:
            begin
               r_next.reg_rdata[1:0] = r_reg.way_count_sel;
               if (LINK.reg_we)
                  r_next.way_count_sel = LINK.reg_wdata[1:0];
            end
            icc_pkg::ADDR_CTRL2:
            begin
               r_next.reg_rdata[icc_pkg::CTRL2_W-1:0] = r_reg.ctrl2;
               if (LINK.reg_we)
                  r_next.ctrl2 = LINK.reg_wdata[icc_pkg::CTRL2_W-1:0];
            end
            default:
            begin
               // Unmapped addresses read zero and drop writes
               r_next.reg_rdata = 32'h00000000;
            end
         endcase
      end

      // Array access: capture, issue to memory, take data, then ack
      case (r_reg.arr_stage)
         2'h0:
         begin
            if (LINK.arr_req)
            begin
               r_next.arr_stage = 2'h1;
               r_next.mem_req = 1'b1;
               // Writes are dropped unless enabled; nothing else guards them
               r_next.mem_we = LINK.arr_we
                  && r_reg.ctrl2[icc_pkg::CTRL2_WEN_BIT];
               r_next.mem_tag = LINK.arr_tag;
               r_next.mem_addr = LINK.arr_addr;
               r_next.mem_wdata = LINK.arr_wdata;
            end
         end
         2'h1:
            r_next.arr_stage = 2'h2;
         2'h2:
         begin
            r_next.arr_stage = 2'h0;
            r_next.arr_ack = 1'b1;
            r_next.arr_rdata = I_MEM_RDATA;
         end
         default:
            r_next.arr_stage = 2'h0;
      endcase
   end

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         r_reg <= '0;
         r_reg.line_size <= icc_pkg::LINE_RST;
         r_reg.way_count_sel <= icc_pkg::WAY_RST;
         r_reg.ctrl2 <= icc_pkg::CTRL2_RST;
         r_reg.units <= 10'h001;
      end
      else
         r_reg <= r_next;
   end

   // ==========================================
   // Outputs
   assign LINK.reg_ack = r_reg.reg_ack;
   assign LINK.reg_rdata = r_reg.reg_rdata;
   assign LINK.arr_ack = r_reg.arr_ack;
   assign LINK.arr_rdata = r_reg.arr_rdata;

   assign O_CACHEABLE = cacheable;
   // A stale tag could match mid-sweep, so hits are masked until done
   assign O_HIT = I_ACC_VALID && cacheable && I_TAG_HIT && !flush_busy;
   assign O_STALL = I_ACC_VALID && cacheable && flush_busy;
   assign O_LINE_SIZE = r_reg.line_size;
   assign O_WAY_COUNT = r_reg.way_count_sel;
   assign O_CACHE_EN = r_reg.cache_en;
   assign O_FLASH_UNITS = r_reg.units;
   assign O_CLK_GATE_EN = r_reg.ctrl2[icc_pkg::CTRL2_CGEN_BIT];
   assign O_ARRAY_WEN = r_reg.ctrl2[icc_pkg::CTRL2_WEN_BIT];
   assign O_FLUSH_BUSY = flush_busy;
   assign O_TAG_CLR_EN = flush_busy;
   assign O_TAG_CLR_IDX = flush_idx;
   assign O_MEM_REQ = r_reg.mem_req;
   assign O_MEM_WE = r_reg.mem_we;
   assign O_MEM_TAG = r_reg.mem_tag;
   assign O_MEM_ADDR = r_reg.mem_addr;
   assign O_MEM_WDATA = r_reg.mem_wdata;
endmodule : icc_dev
`default_nettype wire

// *** icc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module icc_host (
   input wire logic I_CLK,
   input wire logic I_RST,
   icc_link_if.host LINK,
   input wire logic I_CMD_VALID,
   input wire logic I_CMD_WRITE,
   input wire logic [31:0] I_CMD_ADDR,
   input wire logic [31:0] I_CMD_WDATA,
   input wire logic I_EXEC_UNCACHED,
   output logic O_CMD_READY,
   output logic O_RSP_VALID,
   output logic [31:0] O_RSP_DATA,
   input wire logic I_DBG_VALID,
   input wire logic I_DBG_WRITE,
   input wire logic I_DBG_TAG,
   input wire logic [15:0] I_DBG_ADDR,
   input wire logic [31:0] I_DBG_WDATA,
   output logic O_DBG_READY,
   output logic O_DBG_RSP_VALID,
   output logic [31:0] O_DBG_RSP_DATA
);
   typedef enum logic [1:0] {H_IDLE, H_PRE, H_MAIN, H_POST} icc_hst_type;

   typedef struct packed {
      icc_hst_type st;
      logic wt;
      logic [31:0] op_addr;
      logic [31:0] op_data;
      logic op_we;
      logic [31:0] main_addr;
      logic [31:0] main_data;
      logic main_we;
      logic has_post;
      logic [1:0] way_shadow;
      logic [12:0] ctrl2_shadow;
      logic rsp_valid;
      logic [31:0] rsp_data;
      logic dpend;
      logic dsent;
      logic dwe;
      logic dtag;
      logic [15:0] daddr;
      logic [31:0] dwdata;
      logic drsp_valid;
      logic [31:0] drsp_data;
   } icc_host_type;

   icc_host_type r_reg;
   icc_host_type r_next;
   logic [31:0] wdata_fix;
   logic wr_ctrl1;

   // ==========================================
   // Register command sequencer
   always_comb
   begin
      r_next = r_reg;
      r_next.rsp_valid = 1'b0;
      r_next.drsp_valid = 1'b0;
      wr_ctrl1 = I_CMD_WRITE && (I_CMD_ADDR == icc_pkg::ADDR_CTRL1);
      wdata_fix = I_CMD_WDATA;
      if (wr_ctrl1)
         wdata_fix[icc_pkg::CTRL1_RES_BIT] = 1'b0;

      case (r_reg.st)
         H_IDLE:
         begin
            if (I_CMD_VALID)
            begin
               r_next.main_addr = I_CMD_ADDR;
               r_next.main_data = wdata_fix;
               r_next.main_we = I_CMD_WRITE;
               r_next.has_post = I_CMD_WRITE && (I_CMD_ADDR == icc_pkg::ADDR_LINE)
                  && (I_CMD_WDATA[1:0] == icc_pkg::LINE_8B);
               r_next.wt = 1'b0;
               r_next.st = H_MAIN;
               r_next.op_addr = I_CMD_ADDR;
               r_next.op_data = wdata_fix;
               r_next.op_we = I_CMD_WRITE;
               if (I_CMD_WRITE && (I_CMD_ADDR == icc_pkg::ADDR_WAY)
                  && (I_CMD_WDATA[1:0] < r_reg.way_shadow))
               begin
                  r_next.st = H_PRE;
                  r_next.op_addr = icc_pkg::ADDR_CTRL1;
                  r_next.op_data = icc_pkg::FLUSH_WORD;
                  r_next.op_we = 1'b1;
               end
               else if (wr_ctrl1 && I_CMD_WDATA[icc_pkg::CTRL1_FLUSH_BIT]
                  && I_EXEC_UNCACHED && r_reg.ctrl2_shadow[icc_pkg::CTRL2_CGEN_BIT])
               begin
                  r_next.st = H_PRE;
                  r_next.op_addr = icc_pkg::ADDR_CTRL2;
                  r_next.op_data = {19'h00000, r_reg.ctrl2_shadow};
                  r_next.op_data[icc_pkg::CTRL2_CGEN_BIT] = 1'b0;
                  r_next.op_we = 1'b1;
               end
            end
         end
         H_PRE, H_MAIN, H_POST:
         begin
            if (!r_reg.wt)
               r_next.wt = 1'b1;
            else if (LINK.reg_ack)
            begin
               r_next.wt = 1'b0;
               if (r_reg.op_we && (r_reg.op_addr == icc_pkg::ADDR_WAY))
                  r_next.way_shadow = r_reg.op_data[1:0];
               if (r_reg.op_we && (r_reg.op_addr == icc_pkg::ADDR_CTRL2))
                  r_next.ctrl2_shadow = r_reg.op_data[icc_pkg::CTRL2_W-1:0];
               if (r_reg.st == H_PRE)
               begin
                  r_next.st = H_MAIN;
                  r_next.op_addr = r_reg.main_addr;
                  r_next.op_data = r_reg.main_data;
                  r_next.op_we = r_reg.main_we;
               end
               else if ((r_reg.st == H_MAIN) && r_reg.has_post)
               begin
                  r_next.st = H_POST;
                  r_next.op_addr = icc_pkg::ADDR_CTRL1;
                  r_next.op_data = icc_pkg::FLUSH_WORD;
                  r_next.op_we = 1'b1;
                  r_next.rsp_valid = 1'b1;
                  r_next.rsp_data = LINK.reg_rdata;
               end
               else
               begin
                  r_next.st = H_IDLE;
                  if (r_reg.st == H_MAIN)
                  begin
                     r_next.rsp_valid = 1'b1;
                     r_next.rsp_data = LINK.reg_rdata;
                  end
               end
            end
         end
         default:
            r_next.st = H_IDLE;
      endcase

      // ==========================================
      // Debug array access, one outstanding at a time
      if (!r_reg.dpend)
      begin
         if (I_DBG_VALID)
         begin
            r_next.dpend = 1'b1;
            r_next.dsent = 1'b0;
            r_next.dwe = I_DBG_WRITE;
            r_next.dtag = I_DBG_TAG;
            r_next.daddr = I_DBG_ADDR;
            // Tag array is 16 bits wide, data array a full word
            r_next.dwdata = I_DBG_TAG ? {16'h0000, I_DBG_WDATA[15:0]} : I_DBG_WDATA;
         end
      end
      else if (!r_reg.dsent)
         r_next.dsent = 1'b1;
      else if (LINK.arr_ack)
      begin
         r_next.dpend = 1'b0;
         r_next.drsp_valid = 1'b1;
         r_next.drsp_data = r_reg.dtag
            ? {16'h0000, LINK.arr_rdata[15:0] & icc_pkg::TAG_MASK} : LINK.arr_rdata;
      end
   end

   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         r_reg <= '0;
         r_reg.st <= H_IDLE;
         r_reg.way_shadow <= icc_pkg::WAY_RST;
         r_reg.ctrl2_shadow <= icc_pkg::CTRL2_RST;
      end
      else
         r_reg <= r_next;
   end

   // ==========================================
   // Outputs
   assign LINK.reg_req = (r_reg.st != H_IDLE) && !r_reg.wt;
   assign LINK.reg_we = r_reg.op_we;
   assign LINK.reg_addr = r_reg.op_addr;
   assign LINK.reg_wdata = r_reg.op_data;
   assign LINK.arr_req = r_reg.dpend && !r_reg.dsent;
   assign LINK.arr_we = r_reg.dwe;
   assign LINK.arr_tag = r_reg.dtag;
   assign LINK.arr_addr = r_reg.daddr;
   assign LINK.arr_wdata = r_reg.dwdata;
   assign O_CMD_READY = (r_reg.st == H_IDLE);
   assign O_RSP_VALID = r_reg.rsp_valid;
   assign O_RSP_DATA = r_reg.rsp_data;
   assign O_DBG_READY = !r_reg.dpend;
   assign O_DBG_RSP_VALID = r_reg.drsp_valid;
   assign O_DBG_RSP_DATA = r_reg.drsp_data;
endmodule : icc_host
`default_nettype wire

// *** icc_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module icc_link_props (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic reg_req,
   input wire logic reg_we,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic arr_req,
   input wire logic arr_tag,
   input wire logic [31:0] arr_wdata,
   input wire logic [31:0] arr_rdata,
   input wire logic arr_ack
);
   // ==========================================
   // Shadow registers, rebuilt from link writes
   logic [1:0] line_reg, way_reg;
   logic [12:0] c2_reg;
   logic res_reg, fl_reg, wr1, wrw;
   logic [31:0] exp_rd;
   assign wr1 = reg_req && reg_we && reg_addr == icc_pkg::ADDR_CTRL1;
   assign wrw = reg_req && reg_we && reg_addr == icc_pkg::ADDR_WAY;
   always_comb
   begin
      case (reg_addr)
         icc_pkg::ADDR_CTRL1: exp_rd = {30'h0, res_reg, 1'b0};
         icc_pkg::ADDR_LINE: exp_rd = {30'h0, line_reg};
         icc_pkg::ADDR_WAY: exp_rd = {30'h0, way_reg};
         icc_pkg::ADDR_CTRL2: exp_rd = {19'h0, c2_reg};
         default: exp_rd = 32'h0;
      endcase
   end
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         line_reg <= icc_pkg::LINE_RST;
         way_reg <= icc_pkg::WAY_RST;
         c2_reg <= icc_pkg::CTRL2_RST;
         res_reg <= 1'b0;
         fl_reg <= 1'b0;
      end
      else
      begin
         if (reg_req && reg_we && reg_addr == icc_pkg::ADDR_LINE) line_reg <= reg_wdata[1:0];
         if (reg_req && reg_we && reg_addr == icc_pkg::ADDR_CTRL2) c2_reg <= reg_wdata[12:0];
         if (wrw) way_reg <= reg_wdata[1:0];
         if (wr1) res_reg <= reg_wdata[1];
         // A flush stays credited until the next way write consumes it
         if (wr1 && reg_wdata[0]) fl_reg <= 1'b1;
         else if (wrw) fl_reg <= 1'b0;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   ack_after_req_a: assert property (reg_req |=> reg_ack && !reg_req)
      else $error("register ack missing");
   flush_reads_zero_a: assert property (reg_req && !reg_we && reg_addr == icc_pkg::ADDR_CTRL1
      |=> reg_rdata[0] == 1'b0) else $error("flush bit read as one");
   reserved_zero_a: assert property (wr1 |-> reg_wdata[1] == 1'b0)
      else $error("reserved control bit written");
   reg_readback_a: assert property (reg_req && !reg_we |=> reg_rdata == $past(exp_rd))
      else $error("register read mismatch");
   post_flush_a: assert property (reg_req && reg_we && reg_addr == icc_pkg::ADDR_LINE
      && reg_wdata[1:0] == icc_pkg::LINE_8B |=> ##[1:6] wr1 && reg_wdata == icc_pkg::FLUSH_WORD)
      else $error("no flush after short line");
   lower_way_flush_a: assert property (wrw && reg_wdata[1:0] < way_reg |-> fl_reg)
      else $error("ways lowered without flush");
   arr_ack_lat_a: assert property (arr_req |=> !arr_ack [*2] ##1 arr_ack)
      else $error("array ack latency");
   tag_width_a: assert property (arr_req && arr_tag |-> arr_wdata[31:16] == 16'h0000)
      else $error("tag write wider than 16 bits");
   cover property (wr1 && reg_wdata[0]);
   cover property (wrw && reg_wdata[1:0] < way_reg);
   cover property (arr_req && arr_tag);
endmodule : icc_link_props
`default_nettype wire

// *** instruction_cache_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module instruction_cache_config_tb;
   logic I_CLK = 1'b0, I_RST = 1'b1, cv = 1'b0, cw = 1'b0, unc = 1'b0;
   logic dv = 1'b0, dw = 1'b0, dt = 1'b0, av = 1'b0, af = 1'b0, ao = 1'b0, rm = 1'b0, th = 1'b0;
   logic [31:0] ca = 32'h0, cd = 32'h0, dd = 32'h0, mrd = 32'h0, rs, drs, mwd;
   logic [15:0] da = 16'h0000;
   logic [24:0] off = 25'h0;
   logic crdy, rv, drdy, drv, cach, hit, stl, cen, cge, awen, busy, mwe, we_seen;
   logic [1:0] lsz, wct;
   logic [9:0] units;
   int error_cnt = 0, checked = 0, cyc = 0, bcnt = 0;
   icc_link_if link ();
   icc_dev #(.DATA_KB(8)) i_icc_dev (.I_CLK(I_CLK), .I_RST(I_RST), .LINK(link),
      .I_ACC_VALID(av), .I_ACC_FLASH(af), .I_ACC_OTP(ao), .I_ACC_OFFSET(off), .I_REMAP_OTP(rm),
      .I_TAG_HIT(th), .I_MEM_RDATA(mrd), .O_CACHEABLE(cach), .O_HIT(hit), .O_STALL(stl),
      .O_LINE_SIZE(lsz), .O_WAY_COUNT(wct), .O_CACHE_EN(cen), .O_FLASH_UNITS(units),
      .O_CLK_GATE_EN(cge), .O_ARRAY_WEN(awen), .O_FLUSH_BUSY(busy), .O_TAG_CLR_EN(),
      .O_TAG_CLR_IDX(), .O_MEM_REQ(), .O_MEM_WE(mwe), .O_MEM_TAG(), .O_MEM_ADDR(),
      .O_MEM_WDATA(mwd));
   icc_host i_icc_host (.I_CLK(I_CLK), .I_RST(I_RST), .LINK(link), .I_CMD_VALID(cv),
      .I_CMD_WRITE(cw), .I_CMD_ADDR(ca), .I_CMD_WDATA(cd), .I_EXEC_UNCACHED(unc),
      .O_CMD_READY(crdy), .O_RSP_VALID(rv), .O_RSP_DATA(rs), .I_DBG_VALID(dv), .I_DBG_WRITE(dw),
      .I_DBG_TAG(dt), .I_DBG_ADDR(da), .I_DBG_WDATA(dd), .O_DBG_READY(drdy),
      .O_DBG_RSP_VALID(drv), .O_DBG_RSP_DATA(drs));
   icc_link_props i_icc_link_props (.I_CLK(I_CLK), .I_RST(I_RST), .reg_req(link.reg_req),
      .reg_we(link.reg_we), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
      .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .arr_req(link.arr_req),
      .arr_tag(link.arr_tag), .arr_rdata(link.arr_rdata), .arr_ack(link.arr_ack),
      .arr_wdata(link.arr_wdata));
   always #5 I_CLK = ~I_CLK;
   always @(negedge I_CLK)
   begin
      if (busy === 1'b1) bcnt++;
      if (mwe === 1'b1) we_seen = 1'b1;
   end
   // ==========================================
   // Tasks
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, s, got, exp);
      end
   endtask : chk
   task automatic reg_op(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(negedge I_CLK);
      while (crdy !== 1'b1 && n < 2000)
      begin
         @(negedge I_CLK);
         n++;
      end
      cv = 1'b1;
      cw = w;
      ca = a;
      cd = d;
      @(negedge I_CLK);
      cv = 1'b0;
      n = 0;
      while (rv !== 1'b1 && n < 20)
      begin
         @(negedge I_CLK);
         n++;
      end
      if (n >= 20) chk(32'h0, 32'h1, "no register response");
   endtask : reg_op
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string s);
      reg_op(1'b0, a, 32'h0);
      chk(rs, e, s);
   endtask : rd
   task automatic dbg_op(input logic w, input logic t, input logic [31:0] d);
      int n;
      n = 0;
      @(negedge I_CLK);
      dv = 1'b1;
      dw = w;
      dt = t;
      da = 16'h0004;
      dd = d;
      @(negedge I_CLK);
      dv = 1'b0;
      while (drv !== 1'b1 && n < 20)
      begin
         @(negedge I_CLK);
         n++;
      end
      if (n >= 20) chk(32'h0, 32'h1, "no debug response");
   endtask : dbg_op
   task automatic wait_idle;
      int n;
      n = 0;
      while ((crdy !== 1'b1 || busy !== 1'b0) && n < 2000)
      begin
         @(negedge I_CLK);
         n++;
      end
   endtask : wait_idle
   always @(posedge I_CLK)
   begin
      cyc++;
      // Whole run needs about 1500 cycles; far beyond means a hang
      if (cyc == 30000)
      begin
         error_cnt++;
         summarize();
      end
   end
   // ==========================================
   // Sequence
   logic [1:0] codes [3];
   logic [31:0] fl_exp [3];
   initial
   begin
      repeat (2) @(posedge I_CLK);
      @(negedge I_CLK);
      I_RST = 1'b0;
      rd(icc_pkg::ADDR_CTRL1, 32'h0, "ctrl1 reset");
      rd(icc_pkg::ADDR_LINE, 32'h0, "line reset");
      rd(icc_pkg::ADDR_WAY, 32'h2, "way reset");
      rd(icc_pkg::ADDR_CTRL2, 32'h0, "ctrl2 reset");
      rd(32'h400C3010, 32'h0, "unmapped");
      chk({31'h0, cen}, 32'h0, "enable at reset");
      codes = '{icc_pkg::LINE_16B, icc_pkg::LINE_32B, icc_pkg::LINE_8B};
      fl_exp = '{32'h0, 32'h0, 32'h100};
      for (int i = 0; i < 3; i++)
      begin
         bcnt = 0;
         reg_op(1'b1, icc_pkg::ADDR_LINE, {30'h0, codes[i]});
         wait_idle();
         chk({30'h0, lsz}, {30'h0, codes[i]}, "line size");
         chk(bcnt, fl_exp[i], "flush after line write");
      end
      codes = '{icc_pkg::WAY_2, icc_pkg::WAY_4, icc_pkg::WAY_1};
      fl_exp = '{32'h100, 32'h0, 32'h100};
      for (int i = 0; i < 3; i++)
      begin
         bcnt = 0;
         reg_op(1'b1, icc_pkg::ADDR_WAY, {30'h0, codes[i]});
         wait_idle();
         chk({30'h0, wct}, {30'h0, codes[i]}, "way count");
         chk(bcnt, fl_exp[i], "flush before lowering");
      end
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h5);
      av = 1'b1;
      af = 1'b1;
      th = 1'b1;
      off = 25'h005FFFF;
      @(negedge I_CLK);
      chk({30'h0, cach, hit}, 32'h3, "hit in region");
      bcnt = 0;
      reg_op(1'b1, icc_pkg::ADDR_CTRL1, 32'h3);
      chk({30'h0, stl, hit}, 32'h2, "stall while flushing");
      rd(icc_pkg::ADDR_CTRL1, 32'h0, "flush bit read");
      wait_idle();
      chk(bcnt, 32'h100, "flush length");
      chk({31'h0, hit}, 32'h1, "hit after flush");
      off = 25'h0060000;
      @(negedge I_CLK);
      chk({31'h0, cach}, 32'h0, "beyond region");
      off = 25'h0;
      rm = 1'b1;
      @(negedge I_CLK);
      chk({31'h0, cach}, 32'h0, "flash while remapped");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h1005);
      @(negedge I_CLK);
      chk({31'h0, cach}, 32'h1, "flash also cached");
      rm = 1'b0;
      af = 1'b0;
      ao = 1'b1;
      off = 25'h1FFFFFF;
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h5);
      @(negedge I_CLK);
      chk({31'h0, cach}, 32'h0, "otp uncached");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h805);
      @(negedge I_CLK);
      chk({31'h0, cach}, 32'h1, "otp whole range");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h9FF);
      @(negedge I_CLK);
      chk({22'h0, units}, 32'h100, "cap with otp");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h1FF);
      @(negedge I_CLK);
      chk({22'h0, units}, 32'h200, "full region");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h0);
      @(negedge I_CLK);
      chk({30'h0, cen, cach}, 32'h0, "length zero");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h405);
      chk({31'h0, cge}, 32'h1, "gate on");
      unc = 1'b1;
      reg_op(1'b1, icc_pkg::ADDR_CTRL1, icc_pkg::FLUSH_WORD);
      unc = 1'b0;
      chk({31'h0, cge}, 32'h0, "gate off for flush");
      rd(icc_pkg::ADDR_CTRL2, 32'h5, "gate bit cleared");
      wait_idle();
      we_seen = 1'b0;
      dbg_op(1'b1, 1'b0, 32'hA5A5F00D);
      chk({31'h0, we_seen}, 32'h0, "write blocked");
      reg_op(1'b1, icc_pkg::ADDR_CTRL2, 32'h205);
      chk({31'h0, awen}, 32'h1, "arrays writable");
      dbg_op(1'b1, 1'b1, 32'h1234ABCD);
      chk({31'h0, we_seen}, 32'h1, "write passes");
      chk(mwd, 32'h0000ABCD, "tag write width");
      mrd = 32'h89ABCDEF;
      dbg_op(1'b0, 1'b1, 32'h0);
      chk(drs, 32'h0000CDEF, "tag read width");
      dbg_op(1'b0, 1'b0, 32'h0);
      chk(drs, 32'h89ABCDEF, "data read width");
      summarize();
   end
endmodule : instruction_cache_config_tb
`default_nettype wire
